// [lfs_pkg.sv]
/*
  Shared constants for the LED driver fault supervisor.
  Assumes a 50 MHz system clock; switching-cycle counts come from a tick input.
*/
package lfs_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int SYNC_LOSS_US = 30;
  localparam int SYNC_LOSS_CYC = SYNC_LOSS_US * CLK_MHZ;
  localparam logic [15:0] FAULT_TRIP_COUNT = 16'h8002;
  localparam logic [10:0] SYNC_LOSS_LIMIT = 11'(SYNC_LOSS_CYC);
  localparam int NUM_CH = 2;

  // Supervisor state
  typedef enum logic [2:0] {
    LFS_OFF = 3'h1,
    LFS_RUN = 3'h2,
    LFS_LATCHED = 3'h4
  } lfs_state_t;
endpackage : lfs_pkg

// [lfs_delay_counter.sv]
/*
  Fault delay counter: counts switching ticks while its condition holds.
  Assumes tick is a one-cycle pulse per converter switching cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module lfs_delay_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic cond,
  input wire logic tick,
  output logic expired
);
  import lfs_pkg::*;

  logic [15:0] count_reg;

  // Count while the condition holds, drop to zero when it goes away
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 16'h0000;
    end else if (clear || !cond) begin
      count_reg <= 16'h0000;
    end else if (tick && count_reg != FAULT_TRIP_COUNT) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  assign expired = cond && (count_reg == FAULT_TRIP_COUNT);

  count_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cond |=> count_reg == 16'h0000) else $error("delay counter not reset");
endmodule : lfs_delay_counter
`default_nettype wire

// [lfs_supervisor.sv]
/*
  Protection and sequencing logic of a two-channel LED backlight driver.
  Comparator flags arrive already synchronous to clk; sw_tick marks each
  converter switching cycle. Fault outputs are open-drain enables.
*/
// Overview of operation
// - Enabled channels follow the dimming pulse input directly.
// - Converter switching runs only while some channel operates.
// - Overvoltage discharges soft-start, stops switching until release flag; not latched.
// - Overcurrent discharges soft-start, stops switching while set; not latched.
// - Undervoltage shuts all down until release above upper threshold.
// - Thermal shutdown holds all down until cooled below lower threshold.
// - LED pin low starts counter; expiry latches all off; recovery resets.
// - Delay counters count switching cycles and trip at 32770.
// - LED pin low with overvoltage-open flag latches that channel off at once.
// - LED pin high with output below short limit counts, then latches channel.
// - Under dimming, short check and count only while dimming input high.
// - Short condition vanishing before expiry resets its counter.
// - System fault low on undervoltage, thermal, overvoltage or short-circuit.
// - LED fault low on any open or shorted LED.
// - Latches persist until enable recycles or undervoltage lockout.
// - Only sync rising edges count; internal oscillator after 30 us low.
// - Channel disable low enables both; high turns channel two off.
`timescale 1ns/10ps
`default_nettype none
module lfs_supervisor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic dim_pulse,
  input wire logic channel2_disable,
  input wire logic sync_in,
  input wire logic sw_tick,
  input wire logic undervoltage_lockout_detect,
  input wire logic undervoltage_lockout_release,
  input wire logic thermal_hot,
  input wire logic thermal_cool,
  input wire logic ovp_detect,
  input wire logic ovp_release,
  input wire logic ocp_detect,
  input wire logic ovp_open_flag,
  input wire logic out_below_short,
  input wire logic [lfs_pkg::NUM_CH-1:0] led_pin_low,
  input wire logic [lfs_pkg::NUM_CH-1:0] led_pin_high,
  output logic [lfs_pkg::NUM_CH-1:0] channel_on,
  output logic switch_enable,
  output logic ss_discharge,
  output logic use_internal_osc,
  output logic sync_edge,
  output logic system_fault_n_oe,
  output logic led_fault_n_oe
);
  import lfs_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  lfs_state_t state_reg, state_next;
  logic undervoltage_lockout_reg;
  logic thermal_reg;
  logic ovp_reg;
  logic [NUM_CH-1:0] open_latch_reg;
  logic [NUM_CH-1:0] short_latch_reg;
  logic [NUM_CH-1:0] short_expired;
  logic [NUM_CH-1:0] ch_allowed;
  logic [NUM_CH-1:0] ch_active;
  logic scp_expired;
  logic shutdown;
  logic latch_clear;
  logic sync_prev_reg;
  logic [10:0] sync_low_cnt_reg;
  logic internal_osc_reg;
  logic sync_edge_reg;
  logic [NUM_CH-1:0] chan_on_reg;
  logic sw_en_reg;
  logic ss_dis_reg;

  // Latches clear on disable or on undervoltage
  assign latch_clear = !enable || undervoltage_lockout_reg;

  // Undervoltage lockout with hysteresis
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      undervoltage_lockout_reg <= 1'b1;
    end else if (undervoltage_lockout_detect) begin
      undervoltage_lockout_reg <= 1'b1;
    end else if (undervoltage_lockout_release) begin
      undervoltage_lockout_reg <= 1'b0;
    end
  end

  // Thermal shutdown with hysteresis
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thermal_reg <= 1'b0;
    end else if (thermal_hot) begin
      thermal_reg <= 1'b1;
    end else if (thermal_cool) begin
      thermal_reg <= 1'b0;
    end
  end

  // Overvoltage hold until release flag, never latched beyond that
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovp_reg <= 1'b0;
    end else if (ovp_detect) begin
      ovp_reg <= 1'b1;
    end else if (ovp_release) begin
      ovp_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Short-circuit timer and shutdown state
  // ----------------------------------------
  lfs_delay_counter u_scp_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .clear(latch_clear || state_reg != LFS_RUN),
    .cond(|(led_pin_low & ch_allowed)),
    .tick(sw_tick),
    .expired(scp_expired)
  );

  // Off, running, or latched off by short circuit
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LFS_OFF: begin
        if (enable && !undervoltage_lockout_reg && !thermal_reg) state_next = LFS_RUN;
      end
      LFS_RUN: begin
        if (!enable || undervoltage_lockout_reg || thermal_reg) state_next = LFS_OFF;
        else if (scp_expired) state_next = LFS_LATCHED;
      end
      LFS_LATCHED: begin
        if (latch_clear) state_next = LFS_OFF;
      end
      default: state_next = LFS_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LFS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  assign shutdown = state_reg != LFS_RUN;

  // ----------------------------------------
  // Per-channel open and short latches
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      // Channel two can be disabled by the select pin
      assign ch_allowed[ch] = (ch == 0) ? 1'b1 : !channel2_disable;

      lfs_delay_counter u_short_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .clear(latch_clear || shutdown),
        // Dimming low pauses the short count rather than resetting it
        .cond(ch_active[ch] && (!dim_pulse || (led_pin_high[ch] && out_below_short))),
        .tick(sw_tick && dim_pulse),
        .expired(short_expired[ch])
      );

      // Short latch; set wins over clear
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          short_latch_reg[ch] <= 1'b0;
        end else if (short_expired[ch]) begin
          short_latch_reg[ch] <= 1'b1;
        end else if (latch_clear) begin
          short_latch_reg[ch] <= 1'b0;
        end
      end

      // Open latch, immediate
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          open_latch_reg[ch] <= 1'b0;
        end else if (!shutdown && ch_active[ch] && led_pin_low[ch] && ovp_open_flag) begin
          open_latch_reg[ch] <= 1'b1;
        end else if (latch_clear) begin
          open_latch_reg[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  assign ch_active = ch_allowed & ~open_latch_reg & ~short_latch_reg;

  // ----------------------------------------
  // Channel and converter drive
  // ----------------------------------------
  // Channels follow the dimming pulse when permitted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_on_reg <= '0;
    end else if (shutdown) begin
      chan_on_reg <= '0;
    end else begin
      chan_on_reg <= ch_active & {NUM_CH{dim_pulse}};
    end
  end

  // Switching only while a channel conducts and no overvoltage or overcurrent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_en_reg <= 1'b0;
      ss_dis_reg <= 1'b1;
    end else begin
      sw_en_reg <= !shutdown && |(ch_active & {NUM_CH{dim_pulse}})
                   && !ovp_reg && !ocp_detect;
      ss_dis_reg <= shutdown || ovp_reg || ocp_detect;
    end
  end

  assign channel_on = chan_on_reg;
  assign switch_enable = sw_en_reg;
  assign ss_discharge = ss_dis_reg;

  // ----------------------------------------
  // Sync edge detect and oscillator takeover
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_reg <= 1'b0;
      sync_edge_reg <= 1'b0;
    end else begin
      sync_prev_reg <= sync_in;
      sync_edge_reg <= sync_in && !sync_prev_reg;
    end
  end

  // Fall back to internal oscillator after sync stays low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_low_cnt_reg <= 11'h000;
      internal_osc_reg <= 1'b1;
    end else if (sync_in) begin
      sync_low_cnt_reg <= 11'h000;
      if (!sync_prev_reg) internal_osc_reg <= 1'b0;
    end else if (sync_low_cnt_reg != SYNC_LOSS_LIMIT) begin
      sync_low_cnt_reg <= sync_low_cnt_reg + 11'h001;
    end else begin
      internal_osc_reg <= 1'b1;
    end
  end

  assign use_internal_osc = internal_osc_reg;
  assign sync_edge = sync_edge_reg;

  // ----------------------------------------
  // Fault outputs (open-drain pull-low enables)
  // ----------------------------------------
  assign system_fault_n_oe = undervoltage_lockout_reg || thermal_reg || ovp_reg
                             || state_reg == LFS_LATCHED;
  assign led_fault_n_oe = |(open_latch_reg | short_latch_reg);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  dim_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!shutdown && ch_active[0] && !dim_pulse) |=> !channel_on[0])
    else $error("channel on while dimming low");
  switch_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ch_active == '0) |=> !switch_enable) else $error("switching with no channel");
  ovp_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    ovp_detect |=> ##1 (!switch_enable && ss_discharge)) else $error("OVERVOLTAGE_PROTECT ignored");
  ocp_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    ocp_detect |=> (!switch_enable && ss_discharge)) else $error("OVERCURRENT_PROTECT ignored");
  undervoltage_lockout_down_a: assert property (@(posedge clk) disable iff (!rst_n)
    undervoltage_lockout_detect |=> ##1 (state_reg == LFS_OFF) ##1 (channel_on == '0))
    else $error("UNDERVOLTAGE_LOCKOUT did not shut down");
  thermal_down_a: assert property (@(posedge clk) disable iff (!rst_n)
    thermal_hot |=> ##2 (channel_on == '0)) else $error("thermal did not shut down");
  scp_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == LFS_RUN && scp_expired && enable && !undervoltage_lockout_reg && !thermal_reg)
    |=> system_fault_n_oe) else $error("short circuit not latched");
  open_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!shutdown && ch_active[1] && led_pin_low[1] && ovp_open_flag)
    |=> (open_latch_reg[1] && led_fault_n_oe)) else $error("open not latched");
  short_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    short_expired[0] |=> short_latch_reg[0]) else $error("short not latched");
  latch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (open_latch_reg[1] && !latch_clear) |=> open_latch_reg[1]) else $error("latch lost");
  ch2_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    channel2_disable |=> !channel_on[1]) else $error("channel two not disabled");
  sync_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$rose(sync_in) |=> !sync_edge) else $error("sync pulse without rising edge");
  sync_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sync_in) |=> sync_edge) else $error("sync rising edge missed");

  scp_trip_c: cover property (@(posedge clk) disable iff (!rst_n) state_reg == LFS_LATCHED);
  open_trip_c: cover property (@(posedge clk) disable iff (!rst_n) |open_latch_reg);
  short_trip_c: cover property (@(posedge clk) disable iff (!rst_n) |short_latch_reg);
  osc_fallback_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(use_internal_osc));
endmodule : lfs_supervisor
`default_nettype wire

// [lfs_host_model.sv]
/*
  Host controller model driving enable, dimming and sync pins.
  Assumes the bench requests actions through plain level inputs.
*/
`timescale 1ns/10ps
`default_nettype none
module lfs_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en_req,
  input wire logic pwm_mode,
  input wire logic [3:0] duty,
  input wire logic sync_run,
  output logic enable,
  output logic dim_pulse,
  output logic sync_in
);
  logic [3:0] cnt_reg;
  logic [3:0] rdy_reg;
  // Enable first, other pins wait for regulator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= 1'b0;
      rdy_reg <= 4'h0;
      cnt_reg <= 4'h0;
    end else begin
      enable <= en_req;
      rdy_reg <= !enable ? 4'h0 : (rdy_reg == 4'hF ? rdy_reg : rdy_reg + 4'h1);
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // Dimming high when unused; sync fast, low outside bursts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dim_pulse <= 1'b0;
      sync_in <= 1'b0;
    end else begin
      dim_pulse <= (rdy_reg == 4'hF) && (!pwm_mode || cnt_reg < duty);
      sync_in <= (rdy_reg == 4'hF) && sync_run && cnt_reg[1];
    end
  end
endmodule : lfs_host_model
`default_nettype wire

// [lfs_supervisor_bench.sv]
/*
  Self-checking bench: random dimming, fault flags, long delay counts.
  Assumes the package, design files and host model compile first.
*/
`timescale 1ns/10ps
`default_nettype none
module lfs_supervisor_bench;
  import lfs_pkg::*;
  logic clk, rst_n, en_req, pwm_mode, sync_run, c2_dis, tick, prev;
  logic uv_d, uv_r, th_h, th_c, ov_d, ov_r, oc_d, ov_open, below;
  logic enable, dim, sync_in, sw_en, ss_dis, int_osc, s_edge, sf_oe, lf_oe;
  logic [3:0] duty;
  logic [1:0] p_lo, p_hi, chan;
  logic [5:0] st;
  int bad_count, n_tests, n_e, n_s;
  integer seed;
  assign st = {chan, sw_en, ss_dis, sf_oe, lf_oe};

  lfs_host_model i_lfs_host_model (.clk(clk), .rst_n(rst_n), .en_req(en_req),
    .pwm_mode(pwm_mode), .duty(duty), .sync_run(sync_run), .enable(enable),
    .dim_pulse(dim), .sync_in(sync_in));
  lfs_supervisor i_lfs_supervisor (.clk(clk), .rst_n(rst_n), .enable(enable),
    .dim_pulse(dim), .channel2_disable(c2_dis), .sync_in(sync_in), .sw_tick(tick),
    .undervoltage_lockout_detect(uv_d), .undervoltage_lockout_release(uv_r), .thermal_hot(th_h), .thermal_cool(th_c),
    .ovp_detect(ov_d), .ovp_release(ov_r), .ocp_detect(oc_d), .ovp_open_flag(ov_open),
    .out_below_short(below), .led_pin_low(p_lo), .led_pin_high(p_hi), .channel_on(chan),
    .switch_enable(sw_en), .ss_discharge(ss_dis), .use_internal_osc(int_osc),
    .sync_edge(s_edge), .system_fault_n_oe(sf_oe), .led_fault_n_oe(lf_oe));

  // -------------------------------
  // Helpers
  // -------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Expected channel mask from the dimming level and channel-two select
  function automatic logic [1:0] chan_exp(input logic d, input logic c2);
    return {d && !c2, d};
  endfunction : chan_exp
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Bounded wait for masked status, then compare
  task automatic expect_st(input logic [5:0] e, input logic [5:0] m);
    for (int i = 0; i < 12 && (st & m) !== e; i++) cyc(1);
    check({2'h0, st & m}, {2'h0, e});
  endtask : expect_st
  task automatic summarize;
    $display("Compares %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #2000000;
    bad_count++;
    summarize;
  end

  // -------------------------------
  // Scenarios
  // -------------------------------
  initial begin
    seed = 32'hc615;
    bad_count = 0;
    n_tests = 0;
    {rst_n, en_req, pwm_mode, sync_run, c2_dis, tick, uv_d, th_h, ov_d, oc_d} = '0;
    {uv_r, th_c, ov_r, ov_open, below, duty, p_lo, p_hi} = '0;
    cyc(19);
    expect_st(6'h06, 6'h3F);
    cyc(1);
    rst_n = 1'b1;
    uv_r = 1'b1;
    th_c = 1'b1;
    ov_r = 1'b1;
    en_req = 1'b1;
    cyc(24);
    expect_st(6'h38, 6'h3F);
    c2_dis = 1'b1;
    expect_st(6'h18, 6'h3F);
    c2_dis = 1'b0;
    cyc(2);
    // Random duty, channel select held steady
    pwm_mode = 1'b1;
    for (int i = 0; i < 160; i++) begin
      if (i % 16 == 0) duty = 4'($random(seed));
      prev = dim;
      cyc(1);
      check({6'h0, chan}, {6'h0, chan_exp(prev, c2_dis)});
    end
    duty = 4'h0;
    expect_st(6'h00, 6'h38);
    pwm_mode = 1'b0;
    cyc(2);
    ov_r = 1'b0;
    ov_d = 1'b1;
    cyc(1);
    ov_d = 1'b0;
    expect_st(6'h36, 6'h3F);
    cyc(20);
    check({2'h0, st}, 8'h36);
    ov_r = 1'b1;
    expect_st(6'h38, 6'h3F);
    oc_d = 1'b1;
    expect_st(6'h34, 6'h3F);
    oc_d = 1'b0;
    expect_st(6'h38, 6'h3F);
    th_c = 1'b0;
    th_h = 1'b1;
    cyc(1);
    th_h = 1'b0;
    expect_st(6'h02, 6'h3B);
    cyc(20);
    check({2'h0, st & 6'h3B}, 8'h02);
    th_c = 1'b1;
    expect_st(6'h38, 6'h3F);
    // Sync edges counted, then loss of sync
    sync_run = 1'b1;
    n_e = 0;
    n_s = 0;
    for (int i = 0; i < 64; i++) begin
      prev = sync_in;
      cyc(1);
      n_e += int'(sync_in && !prev);
      n_s += int'(s_edge);
    end
    check({7'h0, n_s >= n_e - 1 && n_s <= n_e + 1}, 8'h01);
    check({7'h0, int_osc}, 8'h00);
    sync_run = 1'b0;
    cyc(1400);
    check({7'h0, int_osc}, 8'h00);
    for (int i = 0; i < 200 && int_osc !== 1'b1; i++) cyc(1);
    check({7'h0, int_osc}, 8'h01);
    // Open LED on channel two, then enable recycle
    p_lo = 2'h2;
    ov_open = 1'b1;
    cyc(1);
    p_lo = 2'h0;
    ov_open = 1'b0;
    expect_st(6'h19, 6'h3F);
    cyc(20);
    check({2'h0, st}, 8'h19);
    en_req = 1'b0;
    cyc(4);
    en_req = 1'b1;
    cyc(24);
    expect_st(6'h38, 6'h3F);
    // Short on channel one: gap, dim-low stretch, then full count
    p_hi = 2'h1;
    below = 1'b1;
    tick = 1'b1;
    cyc(100);
    p_hi = 2'h0;
    cyc(2);
    p_hi = 2'h1;
    pwm_mode = 1'b1;
    cyc(100);
    pwm_mode = 1'b0;
    cyc(32760);
    check({2'h0, st}, 8'h38);
    expect_st(6'h29, 6'h3F);
    // Pin low on channel two: gap, then full count
    p_hi = 2'h0;
    below = 1'b0;
    p_lo = 2'h2;
    cyc(100);
    p_lo = 2'h0;
    cyc(2);
    p_lo = 2'h2;
    cyc(32760);
    check({2'h0, st}, 8'h29);
    expect_st(6'h03, 6'h3B);
    p_lo = 2'h0;
    tick = 1'b0;
    cyc(20);
    check({2'h0, st & 6'h3B}, 8'h03);
    uv_r = 1'b0;
    uv_d = 1'b1;
    cyc(2);
    uv_d = 1'b0;
    expect_st(6'h02, 6'h3B);
    cyc(10);
    check({2'h0, st & 6'h3B}, 8'h02);
    uv_r = 1'b1;
    expect_st(6'h38, 6'h3F);
    summarize;
  end
endmodule : lfs_supervisor_bench
`default_nettype wire
